// [rtl/video_input_defs.vh]
// Constants for the video input and host command port
// Function
// - Address-select strap is caught once at start-up and picks one of two 7-bit address pairs.
// - Strap low: answer as bus slave at 0x34 and 0x35.
// - Strap high: answer as bus slave at 0x3A and 0x3B.
// - Strap value also alters the reported USB serial number.
// - After initialisation the strap pin becomes a general-purpose I/O.
// - Commands arrive over the slave bus or USB.
// - Host bus is open-drain; host drives clock, controller is slave.
// - Second bus is a master toward on-board peripherals.
// - Refresh at incoming frame rate; repeat last active frame when none arrives.
// - Video mode accepts up to 30 bits per pixel.
// - Pattern mode keeps upper 8 bits per colour, a 24-bit word.
// - Parallel input carries 10 bits per colour on three lane groups.
// - Parallel inputs are timed by the source pixel clock.
// - Serial port configurable for 24, 27 or 30 bits.
// - Serial port has one clock lane and five data lanes A to E.
// - Lane groups A, B, C can be swapped onto any colour.
`ifndef VIDEO_INPUT_DEFS_VH
`define VIDEO_INPUT_DEFS_VH
`define CLK_PERIOD_NS   8
`define ADDR_LOW_PAIR0  7'h34
`define ADDR_LOW_PAIR1  7'h35
`define ADDR_HIGH_PAIR0 7'h3A
`define ADDR_HIGH_PAIR1 7'h3B
`define CHAN_W          10
`define PIXEL_W         30
`define PATTERN_KEEP    8
`define LANE_A          2'h0
`define LANE_B          2'h1
`define LANE_C          2'h2
`define SER_BITS        7
`define SER_LANES       5
`define SER_MODE_24     2'h0
`define SER_MODE_27     2'h1
`define SER_MODE_30     2'h2
`define SER_W24         24
`define SER_W27         27
`define STRAP_SETTLE    2'h3
`define PERIPH_BIT_NS   10000
`define I2C_IDLE        3'h0
`define I2C_ADDR        3'h1
`define I2C_ACK_A       3'h2
`define I2C_WR          3'h3
`define I2C_ACK_W       3'h4
`define I2C_RD          3'h5
`define I2C_ACK_R       3'h6
`define PM_IDLE         2'h0
`define PM_START        2'h1
`define PM_BITS         2'h2
`define PM_STOP         2'h3
`define PM_ACK_BIT      4'h8
`endif

// [rtl/host_cmd_slave.v]
// Byte-level slave on the host command bus
`timescale 1ns/1ns
`include "video_input_defs.vh"
module host_cmd_slave (
  input  wire       i_clock,
  input  wire       i_rst_n,
  input  wire       i_scl,
  input  wire       i_sda,
  input  wire       i_strap,
  input  wire [7:0] i_reply_byte,
  output reg        o_sda_oe,
  output reg  [7:0] o_byte,
  output reg        o_byte_valid,
  output reg        o_sub_addr,
  output reg        o_read_req
);
  reg  [2:0] state_q;
  reg  [3:0] cnt_q;
  reg  [7:0] sh_q;
  reg  [7:0] tx_q;
  reg        scl_q;
  reg        sda_q;
  reg        ack_ok_q;
  wire       rise  = i_scl & ~scl_q;
  wire       fall  = ~i_scl & scl_q;
  wire       start = scl_q & i_scl & sda_q & ~i_sda;
  wire       stop  = scl_q & i_scl & ~sda_q & i_sda;
  wire [6:0] base0 = i_strap ? `ADDR_HIGH_PAIR0 : `ADDR_LOW_PAIR0;
  wire [6:0] base1 = i_strap ? `ADDR_HIGH_PAIR1 : `ADDR_LOW_PAIR1;
  wire       hit   = (sh_q[7:1] == base0) | (sh_q[7:1] == base1);

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= `I2C_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ack_ok_q <= 1'b0;
      o_sda_oe <= 1'b0;
      o_byte <= 8'h00;
      o_byte_valid <= 1'b0;
      o_sub_addr <= 1'b0;
      o_read_req <= 1'b0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      o_byte_valid <= 1'b0;
      o_read_req <= 1'b0;
      if (start) begin
        state_q <= `I2C_ADDR;
        cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        state_q <= `I2C_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_q)
          `I2C_ADDR, `I2C_WR: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], i_sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (state_q == `I2C_WR) begin
                o_sda_oe <= 1'b1;
                o_byte <= sh_q;
                o_byte_valid <= 1'b1;
                state_q <= `I2C_ACK_W;
              end else if (hit) begin
                o_sda_oe <= 1'b1;
                o_sub_addr <= sh_q[1];
                state_q <= `I2C_ACK_A;
              end else begin
                state_q <= `I2C_IDLE;
              end
            end
          end
          `I2C_ACK_A: begin
            if (fall) begin
              cnt_q <= 4'h0;
              if (sh_q[0]) begin
                tx_q <= i_reply_byte;
                o_sda_oe <= ~i_reply_byte[7];
                o_read_req <= 1'b1;
                state_q <= `I2C_RD;
              end else begin
                o_sda_oe <= 1'b0;
                state_q <= `I2C_WR;
              end
            end
          end
          `I2C_ACK_W: begin
            if (fall) begin
              o_sda_oe <= 1'b0;
              state_q <= `I2C_WR;
            end
          end
          `I2C_RD: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (fall) begin
              if (cnt_q == 4'h8) begin
                o_sda_oe <= 1'b0;
                state_q <= `I2C_ACK_R;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                o_sda_oe <= ~tx_q[6];
              end
            end
          end
          `I2C_ACK_R: begin
            if (rise) begin
              ack_ok_q <= ~i_sda;
            end else if (fall) begin
              cnt_q <= 4'h0;
              if (ack_ok_q) begin
                tx_q <= i_reply_byte;
                o_sda_oe <= ~i_reply_byte[7];
                o_read_req <= 1'b1;
                state_q <= `I2C_RD;
              end else begin
                state_q <= `I2C_IDLE;
              end
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // host_cmd_slave

// [rtl/video_input_host_port.v]
// Video input path, host command path and peripheral bus master
`timescale 1ns/1ns
`include "video_input_defs.vh"
module video_input_host_port #(
  parameter IDX_W = 4
) (
  input  wire        i_clock,
  input  wire        i_rst_n,
  input  wire        i_power_good_in,
  input  wire        i_power_on_sense_in,
  input  wire        i_init_done,
  input  wire        i_addr_sel_in,
  input  wire        i_gpio_out,
  input  wire        i_gpio_oe,
  input  wire        i_host_bus_clock_line,
  input  wire        i_host_bus_data_line,
  input  wire [7:0]  i_reply_byte,
  input  wire [7:0]  i_usb_cmd_byte,
  input  wire        i_usb_cmd_valid,
  input  wire        i_peripheral_bus_clock_line,
  input  wire        i_peripheral_bus_data_line,
  input  wire        i_periph_start,
  input  wire [7:0]  i_periph_byte,
  input  wire        i_source_pixel_clock,
  input  wire        i_frame_sync_in,
  input  wire        i_line_sync_in,
  input  wire        i_pixel_valid_in,
  input  wire [29:0] i_color_lane_groups,
  input  wire        i_pattern_mode,
  input  wire [5:0]  i_lane_map,
  input  wire        i_lvds_clock_lane,
  input  wire        i_lvds_lane_a,
  input  wire        i_lvds_lane_b,
  input  wire        i_lvds_lane_c,
  input  wire        i_lvds_lane_d,
  input  wire        i_lvds_lane_e,
  input  wire [1:0]  i_lvds_mode,
  output wire        o_ready,
  output reg         o_strap,
  output wire        o_usb_serial_variant,
  output wire        o_gpio_in,
  output wire        o_addr_sel_out,
  output wire        o_addr_sel_oe,
  output wire        o_host_bus_data_line_out,
  output wire        o_host_bus_data_line_oe,
  output wire        o_host_bus_clock_line_out,
  output wire        o_host_bus_clock_line_oe,
  output reg  [7:0]  o_cmd_byte,
  output reg         o_cmd_valid,
  output reg         o_cmd_from_usb,
  output wire        o_cmd_sub_addr,
  output wire        o_reply_req,
  output wire        o_peripheral_bus_clock_line_out,
  output reg         o_peripheral_bus_clock_line_oe,
  output wire        o_peripheral_bus_data_line_out,
  output reg         o_peripheral_bus_data_line_oe,
  output wire        o_periph_busy,
  output reg         o_periph_nack,
  output reg  [29:0] o_pixel,
  output reg         o_pixel_valid,
  output reg         o_frame_start,
  output reg         o_frame_repeat,
  output reg  [15:0] o_frame_lines,
  output reg  [29:0] o_lvds_word,
  output reg         o_lvds_valid
);
  localparam DEPTH = 1 << IDX_W;
  localparam QTR_CNT = `PERIPH_BIT_NS / (4 * `CLK_PERIOD_NS);
  localparam SW = 46;
  // Every pin from outside passes two flops before use
  wire [SW-1:0] pins = {i_power_good_in, i_power_on_sense_in, i_addr_sel_in,
                        i_host_bus_clock_line, i_host_bus_data_line,
                        i_peripheral_bus_data_line, i_source_pixel_clock,
                        i_frame_sync_in, i_line_sync_in, i_pixel_valid_in,
                        i_color_lane_groups, i_lvds_clock_lane, i_lvds_lane_e,
                        i_lvds_lane_d, i_lvds_lane_c, i_lvds_lane_b, i_lvds_lane_a};
  reg  [SW-1:0] meta_q;
  reg  [SW-1:0] sync_q;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {SW{1'b0}};
      sync_q <= {SW{1'b0}};
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end
  wire        run      = sync_q[45] & sync_q[44];
  wire        strap_s  = sync_q[43];
  wire        hscl_s   = sync_q[42] | ~run;
  wire        hsda_s   = sync_q[41] | ~run;
  wire        psda_s   = sync_q[40];
  wire        pclk_s   = sync_q[39];
  wire        fsync_s  = sync_q[38];
  wire        lsync_s  = sync_q[37];
  wire        pvalid_s = sync_q[36];
  wire [29:0] lanes_s  = sync_q[35:6];
  wire        lclk_s   = sync_q[5];
  wire [4:0]  ser_s    = sync_q[4:0];
  assign o_ready = run;

  // Strap caught once the pin pipeline has filled after reset
  reg [1:0] settle_q;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_q <= 2'h0;
      o_strap <= 1'b0;
    end else if (settle_q != `STRAP_SETTLE) begin
      settle_q <= settle_q + 2'h1;
      o_strap <= strap_s;
    end
  end
  assign o_usb_serial_variant = o_strap;
  assign o_gpio_in      = i_init_done & strap_s;
  assign o_addr_sel_out = 1'b0;
  assign o_addr_sel_oe  = i_init_done & i_gpio_oe & ~i_gpio_out;

  // Host command slave plus USB commands on one port
  wire [7:0] slv_byte;
  wire       slv_valid;
  wire       slv_oe;
  host_cmd_slave u_slave (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_scl        (hscl_s),
    .i_sda        (hsda_s),
    .i_strap      (o_strap),
    .i_reply_byte (i_reply_byte),
    .o_sda_oe     (slv_oe),
    .o_byte       (slv_byte),
    .o_byte_valid (slv_valid),
    .o_sub_addr   (o_cmd_sub_addr),
    .o_read_req   (o_reply_req)
  );
  assign o_host_bus_data_line_out  = 1'b0;
  assign o_host_bus_data_line_oe   = slv_oe & run;
  assign o_host_bus_clock_line_out = 1'b0;
  assign o_host_bus_clock_line_oe  = 1'b0;
  // Bus byte wins; a USB byte in the same cycle is dropped, USB side retries
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_byte <= 8'h00;
      o_cmd_valid <= 1'b0;
      o_cmd_from_usb <= 1'b0;
    end else begin
      o_cmd_valid <= run & (slv_valid | i_usb_cmd_valid);
      if (slv_valid) begin
        o_cmd_byte <= slv_byte;
        o_cmd_from_usb <= 1'b0;
      end else if (i_usb_cmd_valid) begin
        o_cmd_byte <= i_usb_cmd_byte;
        o_cmd_from_usb <= 1'b1;
      end
    end
  end

  // Peripheral bus master, one byte per start/stop, no clock stretching
  reg [1:0]  pm_q;
  reg [1:0]  ph_q;
  reg [3:0]  bit_q;
  reg [7:0]  pbyte_q;
  reg [11:0] div_q;
  wire       tick = (div_q == QTR_CNT - 1);
  assign o_periph_busy = (pm_q != `PM_IDLE);
  assign o_peripheral_bus_clock_line_out = 1'b0;
  assign o_peripheral_bus_data_line_out  = 1'b0;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pm_q <= `PM_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      pbyte_q <= 8'h00;
      div_q <= 12'h000;
      o_periph_nack <= 1'b0;
      o_peripheral_bus_clock_line_oe <= 1'b0;
      o_peripheral_bus_data_line_oe <= 1'b0;
    end else begin
      div_q <= (tick || pm_q == `PM_IDLE) ? 12'h000 : div_q + 12'h001;
      case (pm_q)
        `PM_IDLE: begin
          if (i_periph_start && run) begin
            pbyte_q <= i_periph_byte;
            o_peripheral_bus_data_line_oe <= 1'b1;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            pm_q <= `PM_START;
          end
        end
        `PM_START: begin
          if (tick) begin
            pm_q <= `PM_BITS;
          end
        end
        `PM_BITS: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: o_peripheral_bus_clock_line_oe <= 1'b1;
              2'h1: o_peripheral_bus_data_line_oe <=
                      (bit_q != `PM_ACK_BIT) & ~pbyte_q[7 - bit_q[2:0]];
              2'h2: o_peripheral_bus_clock_line_oe <= 1'b0;
              default: begin
                if (bit_q == `PM_ACK_BIT) begin
                  o_periph_nack <= psda_s;
                  pm_q <= `PM_STOP;
                end
                bit_q <= bit_q + 4'h1;
              end
            endcase
          end
        end
        `PM_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin
                o_peripheral_bus_clock_line_oe <= 1'b1;
                o_peripheral_bus_data_line_oe <= 1'b1;
              end
              2'h1: o_peripheral_bus_clock_line_oe <= 1'b0;
              2'h2: o_peripheral_bus_data_line_oe <= 1'b0;
              default: pm_q <= `PM_IDLE;
            endcase
          end
        end
        default: pm_q <= `PM_IDLE;
      endcase
    end
  end

  // Pixel path on edges of the sampled pixel clock
  reg  pclk_q;
  wire px_edge = pclk_s & ~pclk_q & run;
  reg  fsync_q;
  reg  lsync_q;
  function [9:0] pick_group;
    input [1:0]  sel;
    input [29:0] lanes;
    begin
      case (sel)
        `LANE_A: pick_group = lanes[9:0];
        `LANE_B: pick_group = lanes[19:10];
        default: pick_group = lanes[29:20];
      endcase
    end
  endfunction
  wire [9:0]  red = pick_group(i_lane_map[5:4], lanes_s);
  wire [9:0]  grn = pick_group(i_lane_map[3:2], lanes_s);
  wire [9:0]  blu = pick_group(i_lane_map[1:0], lanes_s);
  wire [9:0]  pmask = {{`PATTERN_KEEP{1'b1}}, {(`CHAN_W - `PATTERN_KEEP){~i_pattern_mode}}};
  wire [29:0] pix_in = {red & pmask, grn & pmask, blu & pmask};

  // Two banks: one filling, the other replayed every frame
  reg [29:0]      store_q [0:2*DEPTH-1];
  reg             wbank_q;
  reg             rbank_q;
  reg [IDX_W:0]   widx_q;
  reg             got_q;
  reg [IDX_W:0]   ridx_q;
  reg             ract_q;
  reg [15:0]      lines_q;
  wire fs_edge = px_edge & fsync_s & ~fsync_q;
  wire wr_en   = px_edge & pvalid_s & ~widx_q[IDX_W];
  genvar g;
  generate
    for (g = 0; g < 2 * DEPTH; g = g + 1) begin : g_store
      always @(posedge i_clock) begin
        if (wr_en && {wbank_q, widx_q[IDX_W-1:0]} == g) begin
          store_q[g] <= pix_in;
        end
      end
    end
  endgenerate
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pclk_q <= 1'b0;
      fsync_q <= 1'b0;
      lsync_q <= 1'b0;
      wbank_q <= 1'b0;
      rbank_q <= 1'b1;
      widx_q <= {(IDX_W+1){1'b0}};
      got_q <= 1'b0;
      ridx_q <= {(IDX_W+1){1'b0}};
      ract_q <= 1'b0;
      lines_q <= 16'h0000;
      o_frame_lines <= 16'h0000;
      o_frame_start <= 1'b0;
      o_frame_repeat <= 1'b0;
      o_pixel <= 30'h00000000;
      o_pixel_valid <= 1'b0;
    end else begin
      pclk_q <= pclk_s;
      o_frame_start <= 1'b0;
      o_pixel_valid <= 1'b0;
      if (px_edge) begin
        fsync_q <= fsync_s;
        lsync_q <= lsync_s;
        if (lsync_s && !lsync_q) begin
          lines_q <= lines_q + 16'h0001;
        end
      end
      if (wr_en) begin
        widx_q <= widx_q + 1'b1;
        got_q <= 1'b1;
      end
      if (fs_edge) begin
        widx_q <= {(IDX_W+1){1'b0}};
        got_q <= 1'b0;
        lines_q <= 16'h0000;
        o_frame_lines <= lines_q;
        o_frame_start <= 1'b1;
        o_frame_repeat <= ~got_q;
        ridx_q <= {(IDX_W+1){1'b0}};
        ract_q <= 1'b1;
        if (got_q) begin
          rbank_q <= wbank_q;
          wbank_q <= ~wbank_q;
        end
      end else if (ract_q) begin
        o_pixel <= store_q[{rbank_q, ridx_q[IDX_W-1:0]}];
        o_pixel_valid <= 1'b1;
        ridx_q <= ridx_q + 1'b1;
        ract_q <= (ridx_q != DEPTH - 1);
      end
    end
  end

  // Serial port: one bit per lane per clock-lane period, a word every seven periods
  reg [6:0] ser_sh_q [0:`SER_LANES-1];
  reg [2:0] scnt_q;
  reg       lclk_q;
  wire      l_edge = lclk_s & ~lclk_q & run;
  generate
    for (g = 0; g < `SER_LANES; g = g + 1) begin : g_lane
      always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ser_sh_q[g] <= 7'h00;
        end else if (l_edge) begin
          ser_sh_q[g] <= {ser_sh_q[g][5:0], ser_s[g]};
        end
      end
    end
  endgenerate
  wire [34:0] ser_all = {ser_sh_q[4], ser_sh_q[3], ser_sh_q[2], ser_sh_q[1], ser_sh_q[0]};
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lclk_q <= 1'b0;
      scnt_q <= 3'h0;
      o_lvds_word <= 30'h00000000;
      o_lvds_valid <= 1'b0;
    end else begin
      lclk_q <= lclk_s;
      o_lvds_valid <= 1'b0;
      if (l_edge) begin
        scnt_q <= (scnt_q == `SER_BITS - 1) ? 3'h0 : scnt_q + 3'h1;
      end
      if (l_edge && scnt_q == 3'h0 && lclk_q == 1'b0) begin
        o_lvds_valid <= 1'b1;
        case (i_lvds_mode)
          `SER_MODE_24: o_lvds_word <= {6'h00, ser_all[`SER_W24-1:0]};
          `SER_MODE_27: o_lvds_word <= {3'h0, ser_all[`SER_W27-1:0]};
          default:      o_lvds_word <= ser_all[29:0];
        endcase
      end
    end
  end
endmodule // video_input_host_port

// [bench/video_input_host_port_assertions.sv]
// Checker for the video input and host command port
`timescale 1ns/1ns
module video_input_host_port_assertions (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_power_good_in,
  input wire i_init_done,
  input wire o_ready,
  input wire o_strap,
  input wire o_usb_serial_variant,
  input wire o_gpio_in,
  input wire o_host_bus_clock_line_oe,
  input wire o_cmd_valid,
  input wire o_peripheral_bus_clock_line_oe,
  input wire o_periph_busy,
  input wire o_frame_start,
  input wire o_pixel_valid
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Pin turns GPIO later, so its level must not leak back
  property p_strap_hold; $past(i_rst_n, 4) |-> $stable(o_strap); endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
  property p_serial; o_usb_serial_variant == o_strap; endproperty
  a_serial: assert property (p_serial) else $error("serial variant off");
  property p_gpio; o_gpio_in |-> i_init_done; endproperty
  a_gpio: assert property (p_gpio) else $error("gpio before init");
  property p_cmd; o_cmd_valid |=> !o_cmd_valid; endproperty
  a_cmd: assert property (p_cmd) else $error("command pulse long");
  property p_slave; !o_host_bus_clock_line_oe; endproperty
  a_slave: assert property (p_slave) else $error("slave drove clock");
  property p_master; o_peripheral_bus_clock_line_oe |-> o_periph_busy; endproperty
  a_master: assert property (p_master) else $error("clock while idle");
  property p_burst; o_frame_start |=> o_pixel_valid [*8]; endproperty
  a_burst: assert property (p_burst) else $error("short burst");
  property p_power; !i_power_good_in [*3] |-> !o_ready; endproperty
  a_power: assert property (p_power) else $error("ready without power");
endmodule // video_input_host_port_assertions
bind video_input_host_port video_input_host_port_assertions u_chk (
  .i_clock, .i_rst_n, .i_power_good_in, .i_init_done, .o_ready, .o_strap,
  .o_usb_serial_variant, .o_gpio_in, .o_host_bus_clock_line_oe, .o_cmd_valid,
  .o_peripheral_bus_clock_line_oe, .o_periph_busy, .o_frame_start, .o_pixel_valid
);

// [bench/video_source_model.sv]
// Video source model driving the parallel pixel port
`timescale 1ns/1ns
module video_source_model (
  input  wire        i_send,
  output reg         o_pclk,
  output reg         o_vs,
  output reg         o_hs,
  output reg         o_de,
  output reg  [29:0] o_data
);
  reg     send_q;
  integer l, p;
  function [29:0] pix(input [9:0] k);
    pix = {k + 10'h301, k + 10'h0A2, k + 10'h053};
  endfunction
  always #80 o_pclk = ~o_pclk;
  initial begin
    {o_pclk, o_vs, o_hs, o_de, send_q} = 5'h00;
    o_data = 30'h0;
    // Syncs never stop, even with nothing to send
    forever begin
      @(negedge o_pclk) o_vs = 1'b1;
      send_q = i_send;
      repeat (2) @(negedge o_pclk);
      o_vs = 1'b0;
      for (l = 0; l < 2; l = l + 1) begin
        @(negedge o_pclk) o_hs = 1'b1;
        @(negedge o_pclk) o_hs = 1'b0;
        for (p = 0; p < 8; p = p + 1) begin
          o_de = send_q;
          o_data = send_q ? pix(10'(l * 8 + p)) : ~o_data;
          @(negedge o_pclk);
        end
        o_de = 1'b0;
        o_data = ~o_data;
      end
    end
  end
endmodule // video_source_model

// [bench/test_video_input_host_port.sv]
// Self-checking bench for the video input and host command port
`timescale 1ns/1ns
module test_video_input_host_port;
  logic i_clock = 0, i_rst_n = 0, i_power_good_in = 1, i_init_done = 0, i_addr_sel_in = 0;
  logic i_usb_cmd_valid = 0, i_periph_start = 0, i_pattern_mode = 0, i_lvds_clock_lane = 0;
  logic [7:0] i_usb_cmd_byte = 8'h00, i_periph_byte = 8'h00, cmd_b;
  logic [5:0] i_lane_map = 6'h24;
  logic [1:0] i_lvds_mode = 2'h0;
  logic [4:0] lv = 5'h00;
  logic scl_m = 1, sda_m = 1, send = 0, cmd_sub, cmd_usb;
  logic [29:0] lv_word;
  int bad_count = 0, checks = 0, cmd_n = 0;
  wire [29:0] o_pixel, o_lvds_word, i_color_lane_groups;
  wire [15:0] o_frame_lines;
  wire [7:0] o_cmd_byte;
  wire o_ready, o_strap, o_usb_serial_variant, o_gpio_in, o_addr_sel_out, o_addr_sel_oe, o_reply_req;
  wire o_host_bus_data_line_out, o_host_bus_data_line_oe, o_host_bus_clock_line_out, o_host_bus_clock_line_oe;
  wire o_cmd_valid, o_cmd_from_usb, o_cmd_sub_addr, o_peripheral_bus_clock_line_out, o_periph_busy;
  wire o_peripheral_bus_clock_line_oe, o_peripheral_bus_data_line_out, o_peripheral_bus_data_line_oe;
  wire o_periph_nack, o_pixel_valid, o_frame_start, o_frame_repeat, o_lvds_valid;
  wire i_source_pixel_clock, i_frame_sync_in, i_line_sync_in, i_pixel_valid_in;
  wire i_host_bus_data_line = sda_m & ~o_host_bus_data_line_oe;
  wire i_peripheral_bus_clock_line = ~o_peripheral_bus_clock_line_oe;
  wire i_peripheral_bus_data_line = ~o_peripheral_bus_data_line_oe;
  video_input_host_port u_dut (
    .i_clock, .i_rst_n, .i_power_good_in, .i_power_on_sense_in(i_power_good_in), .i_init_done,
    .i_addr_sel_in, .i_gpio_out(1'b0), .i_gpio_oe(1'b0), .i_host_bus_clock_line(scl_m),
    .i_host_bus_data_line, .i_reply_byte(8'h00), .i_usb_cmd_byte, .i_usb_cmd_valid,
    .i_peripheral_bus_clock_line, .i_peripheral_bus_data_line, .i_periph_start, .i_periph_byte,
    .i_source_pixel_clock, .i_frame_sync_in, .i_line_sync_in, .i_pixel_valid_in, .i_color_lane_groups,
    .i_pattern_mode, .i_lane_map, .i_lvds_clock_lane, .i_lvds_lane_a(lv[0]), .i_lvds_lane_b(lv[1]),
    .i_lvds_lane_c(lv[2]), .i_lvds_lane_d(lv[3]), .i_lvds_lane_e(lv[4]), .i_lvds_mode, .o_ready,
    .o_strap, .o_usb_serial_variant, .o_gpio_in, .o_addr_sel_out, .o_addr_sel_oe,
    .o_host_bus_data_line_out, .o_host_bus_data_line_oe, .o_host_bus_clock_line_out,
    .o_host_bus_clock_line_oe, .o_cmd_byte, .o_cmd_valid, .o_cmd_from_usb, .o_cmd_sub_addr,
    .o_reply_req, .o_peripheral_bus_clock_line_out, .o_peripheral_bus_clock_line_oe,
    .o_peripheral_bus_data_line_out, .o_peripheral_bus_data_line_oe, .o_periph_busy, .o_periph_nack,
    .o_pixel, .o_pixel_valid, .o_frame_start, .o_frame_repeat, .o_frame_lines, .o_lvds_word, .o_lvds_valid
  );
  video_source_model u_src (.i_send(send), .o_pclk(i_source_pixel_clock), .o_vs(i_frame_sync_in),
    .o_hs(i_line_sync_in), .o_de(i_pixel_valid_in), .o_data(i_color_lane_groups));
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (o_cmd_valid) begin
      cmd_n <= cmd_n + 1;
      {cmd_b, cmd_sub, cmd_usb} <= {o_cmd_byte, o_cmd_sub_addr, o_cmd_from_usb};
    end
    if (o_lvds_valid) lv_word <= o_lvds_word;
  end
  task hold(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Nine bits, MSB first; the last one is the ack slot
  task send_byte(input logic [7:0] d, output logic ak);
    logic [8:0] w;
    w = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      hold(5);
      sda_m = w[i];
      hold(10);
      scl_m = 1;
      hold(10);
      ak = ~i_host_bus_data_line;
      scl_m = 0;
    end
  endtask
  task t_host(input logic s);
    logic [6:0] ad[4];
    logic a1, a2;
    int c0;
    ad = '{7'h34, 7'h35, 7'h3A, 7'h3B};
    i_rst_n = 0;
    i_init_done = 0;
    i_addr_sel_in = s;
    hold(20);
    i_rst_n = 1;
    hold(6);
    chk(o_strap, s);
    chk(o_usb_serial_variant, s);
    for (int j = 0; j < 4; j++) begin
      c0 = cmd_n;
      sda_m = 0;
      hold(10);
      scl_m = 0;
      send_byte({ad[j], 1'b0}, a1);
      send_byte(8'h5A + j, a2);
      hold(5);
      sda_m = 0;
      hold(10);
      scl_m = 1;
      hold(10);
      sda_m = 1;
      hold(10);
      chk(a1, (j > 1) == s);
      chk(cmd_n - c0, a1);
      if (a1) chk({cmd_usb, cmd_sub, cmd_b}, {1'b0, ad[j][0], 8'(8'h5A + j)});
    end
    // Pin now moves; strap must stay and GPIO waits for init
    i_addr_sel_in = ~s;
    hold(6);
    chk({o_strap, o_gpio_in}, {s, 1'b0});
    i_init_done = 1;
    hold(6);
    chk(o_gpio_in, !s);
  endtask
  task t_usb;
    i_usb_cmd_byte = 8'hC3;
    i_usb_cmd_valid = 1;
    hold(1);
    i_usb_cmd_valid = 0;
    hold(6);
    chk({cmd_usb, cmd_b}, 9'h1C3);
  endtask
  task t_lvds;
    logic [34:0] f;
    for (int m = 0; m < 3; m++) begin
      i_lvds_mode = 2'(m);
      lv = m == 0 ? 5'h15 : m == 1 ? 5'h0A : 5'h13;
      for (int j = 0; j < 5; j++) f[j * 7 +: 7] = {7{lv[j]}};
      repeat (14) begin
        i_lvds_clock_lane = 1;
        hold(10);
        i_lvds_clock_lane = 0;
        hold(10);
      end
      chk(lv_word, m == 0 ? {6'h00, f[23:0]} : m == 1 ? {3'h0, f[26:0]} : f[29:0]);
      lv = ~lv;
    end
  endtask
  task wait_fs;
    int i;
    i = 0;
    hold(1);
    while (o_frame_start !== 1'b1 && i < 3000) begin
      hold(1);
      i++;
    end
    if (i >= 3000) bad_count++;
  endtask
  task t_frames(input logic pat, input logic [5:0] map);
    logic [9:0] a, b, c;
    wait_fs;
    i_pattern_mode = pat;
    i_lane_map = map;
    send = 1;
    wait_fs;
    send = 0;
    // Second pass has no new pixels, so the bank is replayed
    for (int r = 0; r < 2; r++) begin
      wait_fs;
      for (int k = 0; k < 16; k++) begin
        hold(1);
        a = k + 10'h053;
        b = k + 10'h0A2;
        c = k + 10'h301;
        if (pat) {a[1:0], b[1:0], c[1:0]} = 6'h00;
        if (k == 0) chk({o_frame_repeat, o_frame_lines}, {r[0], 16'h0002});
        chk(o_pixel_valid, 1);
        chk(o_pixel, map == 6'h06 ? {a, b, c} : {c, b, a});
      end
    end
  endtask
  task t_periph;
    int n;
    i_periph_byte = 8'hA5;
    i_periph_start = 1;
    hold(1);
    i_periph_start = 0;
    hold(2000);
    i_periph_start = 1;
    hold(1);
    i_periph_start = 0;
    n = 0;
    while (o_periph_busy === 1'b1 && n < 20000) begin
      hold(1);
      n++;
    end
    chk(n > 10700 && n < 10900, 1);
    chk(o_periph_nack, 1);
  endtask
  initial begin
    #400_000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    t_host(1);
    t_host(0);
    t_usb;
    t_lvds;
    t_frames(0, 6'h24);
    t_frames(1, 6'h06);
    t_periph;
    i_power_good_in = 0;
    hold(4);
    chk(o_ready, 0);
    tally_and_finish;
  end
endmodule // test_video_input_host_port
